// [hw/bia_arbiter.sv]
// bidding interrupt arbiter: bid formation, threshold compare, capture, global registers
// assumes fifos and timers outside; all inputs but reset_n synchronous to clk_sys
// Function
// - eighteen sources: four rx, four tx, four break, four change-of-state, two timers
// - each source builds a unique bid from fixed, programmed and live bits
// - every cycle bids compare against threshold; exceeding bid raises request
// - winning bid is stored unchanged in the capture register
// - captured value tells channel, type and fifo byte count in one read
// - capture loads on acknowledge or refresh command; host uses one first
// - captured value drives vector modification and global register steering
// - four global addresses: byte count, channel, receive fifo, transmit fifo
// - global receive read returns data of the captured receiver's fifo
// - global transmit write goes to the captured transmitter's fifo
// - global byte count and channel read capture fields right-justified, no storage
// - receiver bid with error: count high, type 111, channel low
// - receiver bid without error: count high, type 011, channel low
// - types: tx x10, break 100, change 001, timer 101, none 000
// - six-bit threshold compares only bid bits 7:2, channel excluded
// - otherwise equal bids go to the highest channel
// - idle timer, empty receiver and full transmitter do not bid
`timescale 1ns/1ns
module bia_arbiter (
  // clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   reset_n,
  // control
  input  wire bia_pkg::bia_ctrl_s     interrupt_control,
  input  wire logic [7:0]             vector_base,
  input  wire bia_pkg::bia_chan_cfg_s chan_cfg [bia_pkg::NCH],
  input  wire bia_pkg::bia_ct_s       ct_stat  [bia_pkg::NCT],
  // per channel status and fifo data
  input  wire bia_pkg::bia_chan_stat_s chan_stat    [bia_pkg::NCH],
  input  wire logic [7:0]             rx_fifo_data [bia_pkg::NCH],
  // acknowledge and command
  input  wire logic                   interrupt_ack_n,
  input  wire logic                   capture_refresh_command,
  // host register port
  input  wire bia_pkg::bia_host_s     host,
  output logic [7:0]                  host_rdata,
  // fifo strobes
  output logic [bia_pkg::NCH-1:0]     rx_pop,
  output logic [bia_pkg::NCH-1:0]     tx_push,
  output logic [7:0]                  tx_data,
  // vector and request pin
  output logic [7:0]                  vector_out,
  output logic [7:0]                  current_interrupt_capture,
  output logic                        irq_pin_out,
  output logic                        irq_pin_oe_n
);

  logic [1:0]          rst_sync_reg;
  logic                rst_n_int;
  bia_pkg::bia_state_s st_reg;
  bia_pkg::bia_state_s st_next;
  logic [7:0]          bid [bia_pkg::NSRC];
  logic [7:0]          win;
  logic                any_hit;
  logic                capture_now;
  logic [7:0]          new_cap;
  logic [1:0]          cap_chan;
  logic [2:0]          cap_count;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n_int = rst_sync_reg[1];

  // bid order 0..3 rx, 4..7 tx, 8..11 break, 12..15 change, 16..17 timers
  genvar g;
  generate
    for (g = 0; g < bia_pkg::NCH; g++) begin : g_chan
      localparam logic [1:0] CH = 2'(g);
      logic [2:0] rxc;
      logic [2:0] txc;
      assign rxc = 3'(chan_stat[g].rx_level - 4'h1);
      assign txc = 3'(chan_stat[g].tx_room - 4'h1);
      always_comb begin
        bid[g]    = 8'h00;
        bid[g+4]  = 8'h00;
        bid[g+8]  = 8'h00;
        bid[g+12] = 8'h00;
        if (chan_cfg[g].rx_en && chan_stat[g].rx_level != 4'h0) begin
          bid[g] = {rxc, chan_stat[g].rx_error ? bia_pkg::TYPE_RX_ERR : bia_pkg::TYPE_RX, CH};
        end
        if (chan_cfg[g].tx_en && chan_stat[g].tx_room != 4'h0) begin
          bid[g+4] = {1'b0, txc, bia_pkg::TYPE_TX_LOW, CH};
        end
        if (chan_cfg[g].brk_en && chan_stat[g].brk) begin
          bid[g+8] = {chan_cfg[g].brk_prio, bia_pkg::TYPE_BRK, CH};
        end
        if (chan_cfg[g].cos_en && chan_stat[g].cos) begin
          bid[g+12] = {chan_cfg[g].cos_prio, bia_pkg::TYPE_COS, CH};
        end
      end
    end
    for (g = 0; g < bia_pkg::NCT; g++) begin : g_ct
      localparam logic [1:0] CT = 2'(g);
      // only a timed-out counter bids
      assign bid[g+16] = (ct_stat[g].en && ct_stat[g].timeout) ?
                         {ct_stat[g].prio, 1'b0, bia_pkg::TYPE_CT, CT} : 8'h00;
    end
  endgenerate

  // full-width max: channel bits only break ties of the upper six
  always_comb begin
    win     = 8'h00;
    any_hit = 1'b0;
    for (int i = 0; i < bia_pkg::NSRC; i++) begin
      if (bid[i][7:bia_pkg::THR_LSB] > interrupt_control.threshold) begin
        any_hit = 1'b1;
        if (bid[i] > win) begin
          win = bid[i];
        end
      end
    end
  end

  assign capture_now = (st_reg.ack_n_prev && !interrupt_ack_n) || capture_refresh_command;
  assign new_cap     = any_hit ? win : {3'h0, bia_pkg::TYPE_NONE, 2'h0};
  assign cap_chan    = st_reg.capture[1:0];

  // byte count sits at different places for rx and tx bids
  always_comb begin
    cap_count = 3'h0;
    if (st_reg.capture[3:2] == bia_pkg::TYPE_RX[1:0]) begin
      cap_count = st_reg.capture[7:bia_pkg::RXCNT_LSB];
    end else if (st_reg.capture[3:2] == bia_pkg::TYPE_TX_LOW) begin
      cap_count = st_reg.capture[6:bia_pkg::TXCNT_LSB];
    end
  end

  always_comb begin
    st_next            = st_reg;
    st_next.irq        = any_hit;
    st_next.ack_n_prev = interrupt_ack_n;
    st_next.rx_pop     = '0;
    st_next.tx_push    = '0;
    if (capture_now) begin
      st_next.capture = new_cap;
      case (interrupt_control.vec_fmt)
        bia_pkg::VEC_FULL:      st_next.vector = vector_base;
        bia_pkg::VEC_CHAN:      st_next.vector = {vector_base[7:2], new_cap[1:0]};
        bia_pkg::VEC_TYPE_CHAN: st_next.vector = {vector_base[7:5], new_cap[4:2], new_cap[1:0]};
        default:                st_next.vector = bia_pkg::VEC_INHIBIT_VALUE;
      endcase
    end
    if (host.rd) begin
      case (host.sel)
        bia_pkg::GSEL_CAPTURE: st_next.rd_data = st_reg.capture;
        bia_pkg::GSEL_BYTE:    st_next.rd_data = {5'h00, cap_count};
        bia_pkg::GSEL_CHAN:    st_next.rd_data = {6'h00, cap_chan};
        bia_pkg::GSEL_RX: begin
          st_next.rd_data          = rx_fifo_data[cap_chan];
          st_next.rx_pop[cap_chan] = 1'b1;
        end
        default:               st_next.rd_data = 8'h00;
      endcase
    end
    if (host.wr && host.sel == bia_pkg::GSEL_TX) begin
      st_next.tx_push[cap_chan] = 1'b1;
      st_next.tx_data           = host.wdata;
    end
  end

  // capture in flight ignores a same-cycle global access: old value steers it
  always_ff @(posedge clk_sys or negedge rst_n_int) begin
    if (!rst_n_int) begin
      st_reg <= '{capture: bia_pkg::CAPTURE_RESET, vector: bia_pkg::VECTOR_RESET, irq: 1'b0,
                  ack_n_prev: 1'b1, rd_data: bia_pkg::RDATA_RESET, rx_pop: '0, tx_push: '0, tx_data: 8'h00};
    end else begin
      st_reg <= st_next;
    end
  end

  assign host_rdata                = st_reg.rd_data;
  assign rx_pop                    = st_reg.rx_pop;
  assign tx_push                   = st_reg.tx_push;
  assign tx_data                   = st_reg.tx_data;
  assign vector_out                = st_reg.vector;
  assign current_interrupt_capture = st_reg.capture;
  assign irq_pin_out               = 1'b0;
  assign irq_pin_oe_n              = ~st_reg.irq;

endmodule // bia_arbiter

// [inc/bia_pkg.sv]
// bidding interrupt arbiter: shared constants, field layouts and carrier types
// assumes one system clock; every status input is synchronous to it
package bia_pkg;

  localparam int unsigned NCH  = 4;
  localparam int unsigned NCT  = 2;
  localparam int unsigned NSRC = 18;

  // type field, bits 4:2 of a bid
  localparam logic [2:0] TYPE_RX_ERR = 3'h7;
  localparam logic [2:0] TYPE_RX     = 3'h3;
  localparam logic [1:0] TYPE_TX_LOW = 2'h2;
  localparam logic [2:0] TYPE_BRK    = 3'h4;
  localparam logic [2:0] TYPE_COS    = 3'h1;
  localparam logic [2:0] TYPE_CT     = 3'h5;
  localparam logic [2:0] TYPE_NONE   = 3'h0;

  // bid field positions
  localparam int unsigned CHAN_LSB   = 0;
  localparam int unsigned TYPE_LSB   = 2;
  localparam int unsigned THR_LSB    = 2;
  localparam int unsigned RXCNT_LSB  = 5;
  localparam int unsigned TXCNT_LSB  = 4;

  // vector formats, interrupt_control[1:0]
  localparam logic [1:0] VEC_FULL      = 2'h0;
  localparam logic [1:0] VEC_CHAN      = 2'h1;
  localparam logic [1:0] VEC_TYPE_CHAN = 2'h2;
  localparam logic [1:0] VEC_INHIBIT   = 2'h3;
  localparam logic [7:0] VEC_INHIBIT_VALUE = 8'hFF;

  // register selects on the host port
  localparam logic [2:0] GSEL_CAPTURE = 3'h0;
  localparam logic [2:0] GSEL_BYTE    = 3'h1;
  localparam logic [2:0] GSEL_CHAN    = 3'h2;
  localparam logic [2:0] GSEL_RX      = 3'h3;
  localparam logic [2:0] GSEL_TX      = 3'h4;

  // values after reset
  localparam logic [7:0] CAPTURE_RESET = 8'h00;
  localparam logic [7:0] VECTOR_RESET  = 8'h00;
  localparam logic [7:0] RDATA_RESET   = 8'h00;

  typedef struct packed {
    logic [3:0] rx_level;   // 0..8 bytes held
    logic       rx_error;
    logic [3:0] tx_room;    // 0..8 free places
    logic       brk;
    logic       cos;
  } bia_chan_stat_s;

  typedef struct packed {
    logic [2:0] brk_prio;
    logic [2:0] cos_prio;
    logic       rx_en;
    logic       tx_en;
    logic       brk_en;
    logic       cos_en;
  } bia_chan_cfg_s;

  typedef struct packed {
    logic       timeout;
    logic [1:0] prio;
    logic       en;
  } bia_ct_s;

  // interrupt_control layout: [7:2] threshold, [1:0] vector format
  typedef struct packed {
    logic [5:0] threshold;
    logic [1:0] vec_fmt;
  } bia_ctrl_s;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] sel;
    logic [7:0] wdata;
  } bia_host_s;

  typedef struct packed {
    logic [7:0]     capture;
    logic [7:0]     vector;
    logic           irq;
    logic           ack_n_prev;
    logic [7:0]     rd_data;
    logic [NCH-1:0] rx_pop;
    logic [NCH-1:0] tx_push;
    logic [7:0]     tx_data;
  } bia_state_s;

endpackage

// [test/bia_ack_model.sv]
// host acknowledge model: answers a pending request with a two-cycle acknowledge
// assumes the bench pulses ack_go for one cycle
`timescale 1ns/1ns
module bia_ack_model (
  // clock
  input  wire logic clk_sys,
  // request and trigger
  input  wire logic irq_pin_oe_n,
  input  wire logic ack_go,
  // acknowledge
  output logic      interrupt_ack_n
);
  initial interrupt_ack_n = 1'b1;
  // only acknowledges a live request, like a real host
  always @(posedge clk_sys) begin
    if (ack_go && !irq_pin_oe_n) begin
      interrupt_ack_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      interrupt_ack_n <= 1'b1;
    end
  end
endmodule // bia_ack_model

// [test/bia_arbiter_props.sv]
// checker for the bidding arbiter: capture, vector, steering and strobe relations
// assumes it is bound to bia_arbiter and sees only its ports
`timescale 1ns/1ns
module bia_arbiter_props (
  // clock and reset
  input wire logic                    clk_sys,
  input wire logic                    reset_n,
  // watched inputs
  input wire bia_pkg::bia_ctrl_s      interrupt_control,
  input wire logic [7:0]              vector_base,
  input wire logic [7:0]              rx_fifo_data [bia_pkg::NCH],
  input wire logic                    interrupt_ack_n,
  input wire logic                    capture_refresh_command,
  input wire bia_pkg::bia_host_s      host,
  // watched outputs
  input wire logic [7:0]              host_rdata,
  input wire logic [bia_pkg::NCH-1:0] rx_pop,
  input wire logic [bia_pkg::NCH-1:0] tx_push,
  input wire logic [7:0]              tx_data,
  input wire logic [7:0]              vector_out,
  input wire logic [7:0]              current_interrupt_capture
);
  logic ack_prev_reg;
  logic cap_now;
  // history reset high so a low ack held through reset counts as a fall
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) ack_prev_reg <= 1'b1;
    else ack_prev_reg <= interrupt_ack_n;
  end
  assign cap_now = (ack_prev_reg && !interrupt_ack_n) || capture_refresh_command;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_loaded;
    cap_now ##1 (current_interrupt_capture != 8'h00);
  endsequence
  sequence s_read(logic [2:0] s);
    host.rd && host.sel == s;
  endsequence
  chk_cap_hold: assert property (!cap_now |=> $stable(current_interrupt_capture))
    else $error("capture changed without a capture event");
  chk_cap_exceeds: assert property (s_loaded |-> current_interrupt_capture[7:2] > $past(interrupt_control.threshold))
    else $error("captured bid does not exceed threshold");
  chk_vec_inhibit: assert property (cap_now && interrupt_control.vec_fmt == bia_pkg::VEC_INHIBIT
    |=> vector_out == bia_pkg::VEC_INHIBIT_VALUE)
    else $error("inhibited vector not all ones");
  chk_vec_chan: assert property (cap_now && interrupt_control.vec_fmt == bia_pkg::VEC_CHAN
    |=> vector_out == {$past(vector_base[7:2]), current_interrupt_capture[1:0]})
    else $error("channel vector wrong");
  chk_chan_read: assert property (s_read(bia_pkg::GSEL_CHAN)
    |=> host_rdata == {6'h00, $past(current_interrupt_capture[1:0])})
    else $error("global channel read wrong");
  chk_rx_steer: assert property (s_read(bia_pkg::GSEL_RX) |=> rx_pop == (4'h1 << $past(current_interrupt_capture[1:0]))
    && host_rdata == $past(rx_fifo_data[current_interrupt_capture[1:0]]))
    else $error("global receive read misdirected");
  chk_pop_pulse: assert property (!(host.rd && host.sel == bia_pkg::GSEL_RX) |=> rx_pop == 4'h0)
    else $error("receive pop without a global read");
  chk_tx_steer: assert property (host.wr && host.sel == bia_pkg::GSEL_TX |=> tx_data == $past(host.wdata)
    && tx_push == (4'h1 << $past(current_interrupt_capture[1:0])))
    else $error("global transmit write misdirected");
endmodule // bia_arbiter_props
bind bia_arbiter bia_arbiter_props chk_u (.*);

// [test/bidding_interrupt_arbiter_tb_top.sv]
// bench for the bidding arbiter: single-source table, then timer, tie, ack, globals, vectors, reset
// assumes bia_arbiter, its checker and the acknowledge model
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module bidding_interrupt_arbiter_tb_top;
  typedef struct packed { logic [1:0] ch; bia_pkg::bia_chan_stat_s st; logic [7:0] exp; } bia_row_s;
  logic                    clk_sys, reset_n, refresh, ack_go, irq_o, irq_oe_n, ack_n;
  logic [7:0]              base, rdata, txd, vec, cap;
  logic [3:0]              pop, push;
  bia_pkg::bia_ctrl_s      ctrl;
  bia_pkg::bia_host_s      host;
  bia_pkg::bia_chan_cfg_s  cfg [bia_pkg::NCH];
  bia_pkg::bia_ct_s        ct [bia_pkg::NCT];
  bia_pkg::bia_chan_stat_s st [bia_pkg::NCH];
  logic [7:0]              rxd [bia_pkg::NCH];
  logic [7:0]              vexp [4] = '{8'hA4, 8'hA7, 8'hAF, 8'hFF};
  bia_row_s                rows [6] = '{{2'h1, 11'h180, 8'h4D}, {2'h3, 11'h440, 8'hFF}, {2'h2, 11'h014, 8'h4A},
                                        {2'h0, 11'h002, 8'hB0}, {2'h2, 11'h001, 8'h46}, {2'h0, 11'h040, 8'h00}};
  int                      err_count, comparisons;
  bia_arbiter dut_u (.clk_sys(clk_sys), .reset_n(reset_n), .interrupt_control(ctrl), .vector_base(base),
    .chan_cfg(cfg), .ct_stat(ct), .chan_stat(st), .rx_fifo_data(rxd), .interrupt_ack_n(ack_n),
    .capture_refresh_command(refresh), .host(host), .host_rdata(rdata), .rx_pop(pop), .tx_push(push),
    .tx_data(txd), .vector_out(vec), .current_interrupt_capture(cap), .irq_pin_out(irq_o),
    .irq_pin_oe_n(irq_oe_n));
  bia_ack_model ack_u (.clk_sys(clk_sys), .irq_pin_oe_n(irq_oe_n), .ack_go(ack_go), .interrupt_ack_n(ack_n));
  task automatic final_report;
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_refresh;
    @(posedge clk_sys);
    refresh <= 1'b1;
    @(posedge clk_sys);
    refresh <= 1'b0;
    #1;
  endtask
  task automatic host_op(input logic rd, input logic [2:0] sel, input logic [7:0] wd);
    @(posedge clk_sys);
    host <= {rd, !rd, sel, wd};
    @(posedge clk_sys);
    host <= '0;
    #1;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // whole run is well under a thousand cycles
  initial begin
    #8000;
    err_count++;
    final_report();
  end
  initial begin
    {reset_n, refresh, ack_go} = 3'h0;
    host = '0;
    base = 8'hA4;
    ctrl = '0;
    ct = '{default: 4'h0};
    st = '{default: 11'h000};
    rxd = '{8'h11, 8'h22, 8'h33, 8'h44};
    cfg = '{default: 10'h2AF};
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      st[rows[i].ch] <= rows[i].st;
      do_refresh();
      `CHK(cap, rows[i].exp)
      `CHK(irq_oe_n, rows[i].exp == 8'h00)
      @(posedge clk_sys);
      st[rows[i].ch] <= '0;
    end
    $display("test single source table done");
    @(posedge clk_sys);
    ct[1] <= 4'hD;
    do_refresh();
    `CHK(cap, 8'h95)
    @(posedge clk_sys);
    ct[1] <= 4'h5;
    do_refresh();
    `CHK(cap, 8'h00)
    $display("test timer done");
    @(posedge clk_sys);
    st[1] <= 11'h100;
    st[3] <= 11'h100;
    ctrl <= 8'h2E;
    do_refresh();
    `CHK(cap, 8'h00)
    `CHK(irq_oe_n, 1'b1)
    @(posedge clk_sys);
    ctrl <= 8'h2A;
    repeat (2) @(posedge clk_sys);
    ack_go <= 1'b1;
    @(posedge clk_sys);
    ack_go <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
    `CHK(cap, 8'h2F)
    $display("test tie and acknowledge done");
    host_op(1'b1, bia_pkg::GSEL_CHAN, 8'h00);
    `CHK(rdata, 8'h03)
    host_op(1'b1, bia_pkg::GSEL_BYTE, 8'h00);
    `CHK(rdata, 8'h01)
    host_op(1'b1, bia_pkg::GSEL_RX, 8'h00);
    `CHK(rdata, 8'h44)
    `CHK(pop, 4'h8)
    host_op(1'b0, bia_pkg::GSEL_TX, 8'h5A);
    `CHK({push, txd}, 12'h85A)
    host_op(1'b1, 3'h6, 8'h00);
    `CHK(rdata, 8'h00)
    $display("test global registers done");
    foreach (vexp[f]) begin
      @(posedge clk_sys);
      ctrl <= {6'h0A, 2'(f)};
      do_refresh();
      `CHK(vec, vexp[f])
    end
    $display("test vector formats done");
    @(posedge clk_sys);
    reset_n <= 1'b0;
    #1;
    `CHK({cap, vec, irq_oe_n}, {bia_pkg::CAPTURE_RESET, bia_pkg::VECTOR_RESET, 1'b1})
    `CHK(irq_o, 1'b0)
    // release again: two sync edges, then request follows the pending bids
    @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK(irq_oe_n, 1'b0)
    `CHK(cap, bia_pkg::CAPTURE_RESET)
    $display("test mid-run reset done");
    final_report();
  end
endmodule // bidding_interrupt_arbiter_tb_top
